// >>> verilog/vic_pkg.sv
// Purpose: Shared constants, types and helpers of the vectored interrupt controller.
// Assumes: 16-bit control registers placed in the low half of 32-bit APB words.
// Notes:   Vector index 0..7 are traps, index 8 onward are user sources.
package vic_pkg;

    localparam int          VIC_NUM_TRAPS      = 8;
    localparam int          VIC_MAX_USER       = 118;
    localparam int          VIC_TABLE_ENTRIES  = 126;
    localparam int          VIC_VEC_W          = 7;
    localparam int          VIC_LVL_W          = 4;
    localparam int          VIC_PRIO_W         = 3;
    localparam int          VIC_ADDR_W         = 24;
    localparam int          VIC_PADDR_W        = 12;

    // Program memory word addresses of the two tables
    localparam logic [23:0] VIC_PRIMARY_BASE   = 24'h000004;
    localparam logic [23:0] VIC_ALT_BASE       = 24'h000104;
    localparam logic [23:0] VIC_RESET_ADDR     = 24'h000000;

    // APB byte offsets
    localparam logic [11:0] VIC_OFF_CTRL_ONE   = 12'h000;
    localparam logic [11:0] VIC_OFF_CTRL_TWO   = 12'h004;
    localparam logic [11:0] VIC_OFF_TEST       = 12'h008;
    localparam logic [11:0] VIC_OFF_CPU_LEVEL  = 12'h00C;
    localparam logic [11:0] VIC_OFF_FLAG_BASE  = 12'h040;
    localparam logic [11:0] VIC_OFF_EN_BASE    = 12'h060;
    localparam logic [11:0] VIC_OFF_PRIO_BASE  = 12'h080;

    // Field positions
    localparam int          VIC_ALT_SEL_BIT    = 15;
    localparam int          VIC_TEST_LVL_LSB   = 8;
    localparam int          VIC_PRIO_STRIDE    = 4;

    // Reset values
    localparam logic [3:0]  VIC_RST_CPU_LEVEL  = 4'h0;
    localparam logic        VIC_RST_ALT_SEL    = 1'b0;

    // Fixed latencies in clock cycles, from accepting edge to done pulse
    localparam int          VIC_ENTRY_CYCLES   = 3;
    localparam int          VIC_RETURN_CYCLES  = 2;

    typedef enum logic [1:0] {
        VIC_IDLE   = 2'b00,
        VIC_FETCH  = 2'b01,
        VIC_LOAD   = 2'b10,
        VIC_RETURN = 2'b11
    } vic_state_t;

    // Vector entry address for a table index
    function automatic logic [23:0] vic_table_addr(input logic [6:0] idx, input logic alt);
        logic [23:0] base;
        base = alt ? VIC_ALT_BASE : VIC_PRIMARY_BASE;
        return base + {16'h0000, idx, 1'b0};
    endfunction

    // Traps sit above all user levels; lower trap index is more urgent
    function automatic logic [3:0] vic_trap_level(input logic [2:0] t);
        return 4'hF - {1'b0, t};
    endfunction

endpackage

// >>> verilog/vic_arbiter.sv
// Purpose: Combinational winner selection among traps and user sources.
// Assumes: user_pend already combines flag and enable.
// Notes:   Ties resolve by ascending index, never by arrival time.
`timescale 1ns/100ps
module vic_arbiter
    import vic_pkg::*;
#(
    parameter int NUM_USER = VIC_MAX_USER
)
(
    input  wire logic [NUM_USER-1:0]   user_pend,  // Flag and enable both set
    input  wire logic [NUM_USER*3-1:0] user_prio,  // Packed 3-bit priorities
    input  wire logic [7:0]            trap_pend,  // Pending trap flags
    input  wire logic [3:0]            cpu_level,  // Current CPU level
    output logic                       win_valid,  // Some source may interrupt
    output logic [6:0]                 win_index,  // Table index of winner
    output logic [3:0]                 win_level   // Level of winner
);

    logic [2:0] best_prio;

    always_comb
    begin
        best_prio = 3'h0;
        win_valid = 1'b0;
        win_index = 7'h00;
        win_level = 4'h0;
        // Strict compare keeps the lower index on a tie and disables level zero
        for (int i = 0; i < NUM_USER; i++)
        begin
            if (user_pend[i] && ({1'b0, user_prio[i*3 +: 3]} > cpu_level)
                && (user_prio[i*3 +: 3] > best_prio))
            begin
                best_prio = user_prio[i*3 +: 3];
                win_valid = 1'b1;
                win_index = 7'(i + VIC_NUM_TRAPS);
                win_level = {1'b0, user_prio[i*3 +: 3]};
            end
        end
        // Downward scan so the lowest pending trap is the final winner
        for (int t = VIC_NUM_TRAPS - 1; t >= 0; t--)
        begin
            if (trap_pend[t] && (vic_trap_level(3'(t)) > cpu_level))
            begin
                win_valid = 1'b1;
                win_index = 7'(t);
                win_level = vic_trap_level(3'(t));
            end
        end
    end

endmodule

// >>> verilog/vic_top.sv
// Purpose: Vectored interrupt controller with APB register file and vector fetch port.
// Assumes: Program memory answers a fetch one cycle after fetch_rd.
// Notes:   Level stack overflow drops the newest push; software must bound nesting.
// Summary of operation
// - All source requests merge into one registered request to the core.
// - Eight trap inputs with sticky flags, independent of user enables.
// - Each user source carries a software-set 3-bit priority, levels 1 to 7.
// - Primary table starts at word 0x000004, entries two words apart.
// - Table index 0..7 are traps, 8..125 are user sources.
// - Fetched 24-bit entry becomes the branch target handed to the core.
// - Equal candidates resolve toward the lower vector index.
// - Same-level ties use fixed index order, not arrival or rotation.
// - Each source owns a distinct table index.
// - Bit 15 of control two selects the alternate table for all vectors.
// - Alternate table at 0x000104, same order, 0x100 above primary.
// - Trap index 1 oscillator, 2 address, 3 stack, 4 math; others reserved.
// - User source has flag, enable and 3-bit priority; source zero at 0x000014.
// - Entry and return each take a fixed cycle count for every source.
// - Reset bypasses arbitration; target is address zero, registers cleared.
// - Flags set by their event and cleared only by software writes or reset.
// - Test register latches requested vector index and new level.
// - CPU level has 3 writable bits and a read-only fourth bit.
`timescale 1ns/100ps
module vic_top
    import vic_pkg::*;
#(
    parameter int NUM_USER    = VIC_MAX_USER,
    parameter int STACK_DEPTH = 16
)
(
    input  wire logic                 pclk,           // System clock
    input  wire logic                 presetn,        // Async reset, active low
    input  wire logic                 psel,           // APB select
    input  wire logic                 penable,        // APB access phase
    input  wire logic                 pwrite,         // APB direction
    input  wire logic [11:0]          paddr,          // APB byte address
    input  wire logic [31:0]          pwdata,         // APB write data
    input  wire logic [3:0]           pstrb,          // APB byte strobes
    output logic [31:0]               prdata,         // APB read data
    output logic                      pready,         // APB ready
    output logic                      pslverr,        // APB error
    input  wire logic [NUM_USER-1:0]  src_event,      // Source request pulses
    input  wire logic [7:0]           trap_event,     // Trap request pulses
    output logic                      irq_req,        // Request to core
    output logic [6:0]                irq_vector,     // Pending table index
    output logic [3:0]                irq_level,      // Pending new level
    input  wire logic                 cpu_ack,        // Core takes request
    input  wire logic                 cpu_return,     // Core returns from handler
    output logic                      fetch_rd,       // Vector entry read
    output logic [23:0]               fetch_addr,     // Vector entry address
    input  wire logic [23:0]          fetch_data,     // Entry read data
    output logic                      entry_done,     // Branch target valid pulse
    output logic [23:0]               branch_target,  // Service routine start
    output logic                      return_done,    // Level restored pulse
    output logic [3:0]                cpu_level       // Current CPU level
);

    localparam int FLAG_WORDS = (NUM_USER + 15) / 16;
    localparam int PRIO_WORDS = (NUM_USER + VIC_PRIO_STRIDE - 1) / VIC_PRIO_STRIDE;
    localparam int SP_W       = $clog2(STACK_DEPTH + 1);
    localparam logic [9:0] IDX_FLAG = VIC_OFF_FLAG_BASE[11:2];
    localparam logic [9:0] IDX_EN   = VIC_OFF_EN_BASE[11:2];
    localparam logic [9:0] IDX_PRIO = VIC_OFF_PRIO_BASE[11:2];

    generate
        if (NUM_USER < 1 || NUM_USER > VIC_MAX_USER || STACK_DEPTH < 1)
        begin : g_bad_param
            $error("vic_top: unsupported NUM_USER or STACK_DEPTH");
        end
    endgenerate

    typedef struct packed {
        vic_state_t                  st;
        logic [NUM_USER-1:0]         flag;
        logic [NUM_USER-1:0]         enable;
        logic [NUM_USER*3-1:0]       prio;
        logic [7:0]                  trap_flag;
        logic                        alt_sel;
        logic [3:0]                  lvl;
        logic [6:0]                  test_vec;
        logic [3:0]                  test_lvl;
        logic                        irq;
        // Level granted at acknowledge, applied once the entry word arrives
        logic [3:0]                  cur_lvl;
        logic                        fetch_rd;
        logic [23:0]                 fetch_addr;
        logic [23:0]                 target;
        logic                        entry_done;
        logic                        return_done;
        logic [STACK_DEPTH-1:0][3:0] stack;
        logic [SP_W-1:0]             sp;
        logic [31:0]                 prdata;
        logic                        slverr;
    } vic_regs_t;

    vic_regs_t r_q;
    vic_regs_t r_d;

    logic        arb_valid;
    logic [6:0]  arb_index;
    logic [3:0]  arb_level;
    logic [15:0] wmask;
    logic        wr_access;
    logic        setup;
    logic [9:0]  widx;

    // Merged pending vector feeds the arbiter
    vic_arbiter #(
        .NUM_USER  (NUM_USER)
    ) u_arb (
        .user_pend (r_q.flag & r_q.enable),
        .user_prio (r_q.prio),
        .trap_pend (r_q.trap_flag),
        .cpu_level (r_q.lvl),
        .win_valid (arb_valid),
        .win_index (arb_index),
        .win_level (arb_level)
    );

    assign wmask     = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wr_access = psel & penable & pwrite;
    assign setup     = psel & ~penable;
    assign widx      = paddr[11:2];

    function automatic logic mapped(input logic [9:0] idx);
        logic ok;
        ok = (idx == VIC_OFF_CTRL_ONE[11:2]) || (idx == VIC_OFF_CTRL_TWO[11:2])
          || (idx == VIC_OFF_TEST[11:2])     || (idx == VIC_OFF_CPU_LEVEL[11:2]);
        ok = ok || (idx >= IDX_FLAG && idx < IDX_FLAG + 10'(FLAG_WORDS));
        ok = ok || (idx >= IDX_EN   && idx < IDX_EN   + 10'(FLAG_WORDS));
        ok = ok || (idx >= IDX_PRIO && idx < IDX_PRIO + 10'(PRIO_WORDS));
        return ok;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [15:0] m);
        return (old & ~m) | (wd & m);
    endfunction

    // Read data view of the current state
    function automatic logic [31:0] read_word(input vic_regs_t s, input logic [9:0] idx);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (idx == VIC_OFF_CTRL_ONE[11:2])
            w[7:0] = s.trap_flag;
        else if (idx == VIC_OFF_CTRL_TWO[11:2])
            w[VIC_ALT_SEL_BIT] = s.alt_sel;
        else if (idx == VIC_OFF_TEST[11:2])
        begin
            w[6:0] = s.test_vec;
            w[VIC_TEST_LVL_LSB +: 4] = s.test_lvl;
        end
        else if (idx == VIC_OFF_CPU_LEVEL[11:2])
            w[3:0] = s.lvl;
        for (int i = 0; i < NUM_USER; i++)
        begin
            if (idx == IDX_FLAG + 10'(i / 16))
                w[i % 16] = s.flag[i];
            if (idx == IDX_EN + 10'(i / 16))
                w[i % 16] = s.enable[i];
            if (idx == IDX_PRIO + 10'(i / VIC_PRIO_STRIDE))
                w[(i % VIC_PRIO_STRIDE) * 4 +: 3] = s.prio[i*3 +: 3];
        end
        return w;
    endfunction

    always_comb
    begin
        logic [15:0] nw;
        nw = 16'h0000;
        r_d = r_q;
        r_d.entry_done  = 1'b0;
        r_d.return_done = 1'b0;

        // APB answers in the access phase with data captured at setup
        if (setup)
        begin
            r_d.prdata = pwrite ? 32'h0000_0000 : read_word(r_q, widx);
            r_d.slverr = ~mapped(widx);
        end

        // Software writes; hardware sets below override clears
        if (wr_access)
        begin
            if (widx == VIC_OFF_CTRL_ONE[11:2])
            begin
                nw = merge16({8'h00, r_q.trap_flag}, pwdata[15:0], wmask);
                r_d.trap_flag = nw[7:0];
            end
            if (widx == VIC_OFF_CTRL_TWO[11:2] && pstrb[1])
                r_d.alt_sel = pwdata[VIC_ALT_SEL_BIT];
            if (widx == VIC_OFF_CPU_LEVEL[11:2] && pstrb[0])
                r_d.lvl[2:0] = pwdata[2:0];
            for (int i = 0; i < NUM_USER; i++)
            begin
                if (widx == IDX_FLAG + 10'(i / 16) && wmask[i % 16])
                    r_d.flag[i] = pwdata[i % 16];
                if (widx == IDX_EN + 10'(i / 16) && wmask[i % 16])
                    r_d.enable[i] = pwdata[i % 16];
                if (widx == IDX_PRIO + 10'(i / VIC_PRIO_STRIDE)
                    && wmask[(i % VIC_PRIO_STRIDE) * 4])
                    r_d.prio[i*3 +: 3] = pwdata[(i % VIC_PRIO_STRIDE) * 4 +: 3];
            end
        end
        r_d.flag      = r_d.flag | src_event;
        r_d.trap_flag = r_d.trap_flag | trap_event;

        case (r_q.st)
            VIC_IDLE:
            begin
                r_d.irq = arb_valid;
                if (arb_valid)
                begin
                    r_d.test_vec = arb_index;
                    r_d.test_lvl = arb_level;
                end
                if (r_q.irq && cpu_ack)
                begin
                    r_d.irq        = 1'b0;
                    // Use the index the core saw, not a winner that changed this cycle
                    r_d.cur_lvl    = r_q.test_lvl;
                    r_d.fetch_rd   = 1'b1;
                    r_d.fetch_addr = vic_table_addr(r_q.test_vec, r_q.alt_sel);
                    r_d.st         = VIC_FETCH;
                end
                else if (cpu_return)
                begin
                    r_d.irq = 1'b0;
                    r_d.st  = VIC_RETURN;
                end
            end
            VIC_FETCH:
            begin
                r_d.fetch_rd = 1'b0;
                r_d.st       = VIC_LOAD;
            end
            VIC_LOAD:
            begin
                r_d.target     = fetch_data;
                r_d.entry_done = 1'b1;
                // Full stack keeps the last slot; deeper nesting loses a level
                if (r_q.sp < SP_W'(STACK_DEPTH))
                begin
                    r_d.stack[r_q.sp] = r_q.lvl;
                    r_d.sp            = r_q.sp + SP_W'(1);
                end
                r_d.lvl = r_q.cur_lvl;
                r_d.st  = VIC_IDLE;
            end
            VIC_RETURN:
            begin
                // Empty stack keeps the level instead of wrapping the pointer
                if (r_q.sp != '0)
                begin
                    r_d.lvl = r_q.stack[r_q.sp - SP_W'(1)];
                    r_d.sp  = r_q.sp - SP_W'(1);
                end
                r_d.return_done = 1'b1;
                r_d.st          = VIC_IDLE;
            end
            default:
            begin
                r_d.st = VIC_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_q             <= '0;
            r_q.st          <= VIC_IDLE;
            r_q.lvl         <= VIC_RST_CPU_LEVEL;
            r_q.alt_sel     <= VIC_RST_ALT_SEL;
            r_q.target      <= VIC_RESET_ADDR;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign prdata        = r_q.prdata;
    assign pready        = 1'b1;
    assign pslverr       = r_q.slverr & psel & penable;
    assign irq_req       = r_q.irq;
    assign irq_vector    = r_q.test_vec;
    assign irq_level     = r_q.test_lvl;
    assign fetch_rd      = r_q.fetch_rd;
    assign fetch_addr    = r_q.fetch_addr;
    assign entry_done    = r_q.entry_done;
    assign branch_target = r_q.target;
    assign return_done   = r_q.return_done;
    assign cpu_level     = r_q.lvl;

endmodule

// >>> testbench/vic_core_model.sv
// Purpose: Core-side partner: acknowledges requests and serves vector fetches.
// Assumes: Entry word of a vector is its own address plus 0x1000.
// Notes:   Fetch data toggles when not being returned, so stale data never matches.
`timescale 1ns/100ps
module vic_core_model
(
    input  wire logic        pclk,        // System clock
    input  wire logic        presetn,     // Async reset, active low
    input  wire logic        irq_req,     // Request from controller
    input  wire logic        ack_en,      // Bench allows acknowledging
    input  wire logic [3:0]  ack_dly,     // Extra cycles before acknowledging
    output logic             cpu_ack,     // Acknowledge pulse
    input  wire logic        fetch_rd,    // Vector read strobe
    input  wire logic [23:0] fetch_addr,  // Vector word address
    output logic [23:0]      fetch_data   // Vector entry contents
);
    logic [3:0] wait_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_q     <= 4'h0;
            cpu_ack    <= 1'b0;
            fetch_data <= 24'h5A5A5A;
        end
        else
        begin
            wait_q  <= irq_req ? wait_q + ((wait_q == 4'hF) ? 4'h0 : 4'h1) : 4'h0;
            cpu_ack <= ack_en && irq_req && !cpu_ack && (wait_q >= ack_dly);
            // One entry per vector, so the target identifies the source
            fetch_data <= fetch_rd ? fetch_addr + 24'h001000 : ~fetch_data;
        end
    end
endmodule

// >>> testbench/vic_top_properties.sv
// Purpose: Concurrent checks on the controller's request and entry ports.
// Assumes: irq_req is only high while the controller is idle.
// Notes:   Alternate select is not visible here, so both table bases are allowed.
`timescale 1ns/100ps
module vic_top_properties
(
    input wire logic        pclk,           // System clock
    input wire logic        presetn,        // Async reset
    input wire logic        psel,           // APB select
    input wire logic        penable,        // APB access phase
    input wire logic        pslverr,        // APB error
    input wire logic [31:0] prdata,         // APB read data
    input wire logic        irq_req,        // Request to core
    input wire logic [6:0]  irq_vector,     // Pending index
    input wire logic [3:0]  irq_level,      // Pending level
    input wire logic        cpu_ack,        // Core takes request
    input wire logic        cpu_return,     // Core returns
    input wire logic        fetch_rd,       // Vector read
    input wire logic [23:0] fetch_addr,     // Vector address
    input wire logic [23:0] fetch_data,     // Entry data
    input wire logic        entry_done,     // Entry pulse
    input wire logic [23:0] branch_target,  // Branch target
    input wire logic        return_done,    // Return pulse
    input wire logic [3:0]  cpu_level       // CPU level
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ack_starts_fetch: assert property (irq_req && cpu_ack |=> fetch_rd && !irq_req)
        else $error("fetch did not follow acknowledge");
    chk_fetch_table_addr: assert property (irq_req && cpu_ack |=>
        fetch_addr == 24'h000004 + {16'h0000, $past(irq_vector), 1'b0} ||
        fetch_addr == 24'h000104 + {16'h0000, $past(irq_vector), 1'b0})
        else $error("vector address wrong");
    chk_entry_latency: assert property (fetch_rd |=> !fetch_rd && !entry_done ##1 entry_done)
        else $error("entry latency wrong");
    chk_target_loaded: assert property (entry_done |-> branch_target == $past(fetch_data))
        else $error("branch target not fetched entry");
    chk_entry_level: assert property (entry_done |-> cpu_level == $past(irq_level, 3))
        else $error("new level not applied");
    chk_return_latency: assert property (return_done |-> $past(cpu_return, 2) && !$past(return_done))
        else $error("return latency wrong");
    chk_trap_level: assert property (irq_req && irq_vector < 7'h08 |-> irq_level == 4'hF - irq_vector[3:0])
        else $error("trap level wrong");
    chk_user_level: assert property (irq_req && irq_vector >= 7'h08 |-> irq_level inside {[4'h1:4'h7]})
        else $error("user level out of range");
    chk_err_access: assert property (pslverr |-> psel && penable && prdata == 32'h0000_0000)
        else $error("error outside access phase or with data");
    chk_reset_start: assert property ($rose(presetn) |-> branch_target == 24'h000000 && cpu_level == 4'h0)
        else $error("reset state wrong");
endmodule

bind vic_top vic_top_properties vic_top_properties_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pslverr(pslverr), .prdata(prdata), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_level(irq_level), .cpu_ack(cpu_ack), .cpu_return(cpu_return), .fetch_rd(fetch_rd),
    .fetch_addr(fetch_addr),
    .fetch_data(fetch_data), .entry_done(entry_done), .branch_target(branch_target),
    .return_done(return_done), .cpu_level(cpu_level));

// >>> testbench/vectored_interrupt_controller_bench.sv
// Purpose: Register, arbitration and entry/return sequence checks of the controller.
// Assumes: Core model returns the vector address plus 0x1000 as entry contents.
// Notes:   Waits are bounded at 100 cycles; a spent bound ends the run.
`timescale 1ns/100ps
module vectored_interrupt_controller_bench
    import vic_pkg::*;
;
    logic         pclk, presetn, psel, penable, pwrite, cpu_return, ack_en, err;
    logic         pready, pslverr, irq_req, cpu_ack, fetch_rd, entry_done, return_done;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [3:0]   pstrb, ack_dly, irq_level, cpu_level;
    logic [117:0] src_event;
    logic [7:0]   trap_event;
    logic [6:0]   irq_vector;
    logic [23:0]  fetch_addr, fetch_data, branch_target;
    int           err_count = 0;
    int           n_tests = 0;

    always #10 pclk = ~pclk;

    vic_top vic_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_event(src_event), .trap_event(trap_event), .irq_req(irq_req), .irq_vector(irq_vector),
        .irq_level(irq_level), .cpu_ack(cpu_ack), .cpu_return(cpu_return), .fetch_rd(fetch_rd),
        .fetch_addr(fetch_addr), .fetch_data(fetch_data), .entry_done(entry_done),
        .branch_target(branch_target), .return_done(return_done), .cpu_level(cpu_level));

    vic_core_model vic_core_model_i (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .ack_en(ack_en),
        .ack_dly(ack_dly), .cpu_ack(cpu_ack), .fetch_rd(fetch_rd), .fetch_addr(fetch_addr),
        .fetch_data(fetch_data));

    task automatic give_verdict();
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Setup then access; held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 100)
            check("pready", 0, 1);
        if (n >= 100)
            give_verdict();
    endtask

    task automatic wait_hi(input int k);
        int n;
        n = 0;
        while (!(k == 0 ? irq_req === 1'b1 : k == 1 ? entry_done === 1'b1 : return_done === 1'b1) && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 100)
            check("wait_bound", k, 32'hFFFF_FFFF);
        if (n >= 100)
            give_verdict();
    endtask

    task automatic take(input logic [6:0] idx, input logic [3:0] lvl, input logic [23:0] base);
        wait_hi(0);
        check("irq_vector", irq_vector, idx);
        check("irq_level", irq_level, lvl);
        ack_en <= 1'b1;
        wait_hi(1);
        ack_en <= 1'b0;
        check("branch_target", branch_target, base + {16'h0000, idx, 1'b0} + 24'h001000);
        check("entry_level", cpu_level, lvl);
    endtask

    task automatic ret(input logic [3:0] lvl);
        cpu_return <= 1'b1;
        @(posedge pclk);
        cpu_return <= 1'b0;
        wait_hi(2);
        check("return_level", cpu_level, lvl);
    endtask

    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
        pstrb = 4'h3; src_event = '0; trap_event = '0; cpu_return = 0; ack_en = 0; ack_dly = 4'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("branch_rst", branch_target, 32'h0);
        apb(1'b0, VIC_OFF_CPU_LEVEL, 32'h0);
        check("cpu_level_rst", rd, 32'h0);
        apb(1'b1, VIC_OFF_CPU_LEVEL, 32'h0000_000F);
        apb(1'b0, VIC_OFF_CPU_LEVEL, 32'h0);
        check("cpu_level_ro", rd, 32'h0000_0007);
        apb(1'b1, VIC_OFF_CPU_LEVEL, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        check("unmapped_err", err, 1'b1);
        // Flag set by its event, kept until software clears it
        src_event[3] <= 1'b1;
        @(posedge pclk);
        src_event <= '0;
        apb(1'b0, VIC_OFF_FLAG_BASE, 32'h0);
        check("flag_set", rd, 32'h0000_0008);
        apb(1'b1, VIC_OFF_FLAG_BASE, 32'h0);
        apb(1'b0, VIC_OFF_FLAG_BASE, 32'h0);
        check("flag_clear", rd, 32'h0);
        // Sources 0..3 at priorities 2, 5, 5, 0
        apb(1'b1, VIC_OFF_PRIO_BASE, 32'h0000_0552);
        apb(1'b1, VIC_OFF_EN_BASE, 32'h0000_000F);
        src_event[3:0] <= 4'hF;
        @(posedge pclk);
        src_event <= '0;
        wait_hi(0);
        apb(1'b0, VIC_OFF_TEST, 32'h0);
        check("test_reg", rd, 32'h0000_0509);
        take(7'd9, 4'd5, VIC_PRIMARY_BASE);
        apb(1'b1, VIC_OFF_FLAG_BASE, 32'h0000_000D);
        check("masked_equal", irq_req, 1'b0);
        apb(1'b1, VIC_OFF_CTRL_TWO, 32'h0000_8000);
        ack_dly <= 4'h3;
        ret(4'd0);
        take(7'd10, 4'd5, VIC_ALT_BASE);
        // Traps 2 and 4 together while a user handler runs
        trap_event <= 8'h14;
        @(posedge pclk);
        trap_event <= 8'h00;
        take(7'd2, 4'd13, VIC_ALT_BASE);
        apb(1'b1, VIC_OFF_CTRL_ONE, 32'h0000_0010);
        ret(4'd5);
        take(7'd4, 4'd11, VIC_ALT_BASE);
        ret(4'd5);
        // Mid-run reset must clear flags, table select and target
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("branch_rst2", branch_target, 32'h0);
        apb(1'b0, VIC_OFF_CTRL_ONE, 32'h0);
        check("trap_flags_rst", rd, 32'h0);
        apb(1'b0, VIC_OFF_CTRL_TWO, 32'h0);
        check("alt_sel_rst", rd, 32'h0);
        apb(1'b1, VIC_OFF_TEST, 32'h0000_0F7F);
        apb(1'b0, VIC_OFF_TEST, 32'h0);
        check("test_reg_ro", rd, 32'h0);
        give_verdict();
    end
endmodule
